// >>> stcp_defs.svh
// Purpose: Offsets, field positions, reset values and mode codes of the
//          standard timer.
// Assumes: Included by bare name from the timer design file.
// Notes:   Definitions only.
`ifndef STCP_DEFS_SVH
`define STCP_DEFS_SVH

`define STCP_OFS_CTRL0  8'h00
`define STCP_OFS_CTRL1  8'h04
`define STCP_OFS_CNTL   8'h08
`define STCP_OFS_CNTH   8'h0C
`define STCP_OFS_CMPAL  8'h10
`define STCP_OFS_CMPAH  8'h14
`define STCP_OFS_FLAGS  8'h18

`define STCP_ON_BIT     3
`define STCP_CMPP_MSB   2
`define STCP_FLAG_A_BIT 0
`define STCP_FLAG_P_BIT 1

`define STCP_BYTE_RST   8'h00
`define STCP_CMPP_RST   3'h0

`define STCP_MODE_CMP   2'h0
`define STCP_MODE_CAP   2'h1
`define STCP_MODE_PWM   2'h2
`define STCP_MODE_TMR   2'h3

`define STCP_ACT_00     2'h0
`define STCP_ACT_01     2'h1
`define STCP_ACT_10     2'h2
`define STCP_ACT_11     2'h3

`endif

// >>> stcp_pkg.sv
// Purpose: Types shared by the standard timer.
// Assumes: Nothing is imported; users write stcp_pkg::name.
// Notes:   Field order of the control type matches its register bits.
package stcp_pkg;

    typedef struct packed {
        logic [1:0] op_mode_sel;
        logic [1:0] out_action_sel;
        logic       out_initial_level;
        logic       out_invert;
        logic       pwm_role_swap;
        logic       clear_source_sel;
    } stcp_ctrl1_t;

    typedef struct packed {
        logic       write;
        logic [7:0] addr;
    } stcp_req_t;

endpackage

// >>> stcp_timer.sv
// Purpose: Standard 10-bit timer with compare output, PWM, capture and
//          timer/counter modes behind an AHB-Lite slave.
// Assumes: count_tick is the selected timer clock as a one-cycle pulse.
// Notes:   Zero wait states; the response is always OKAY.
//
// The AHB-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "stcp_defs.svh"

module stcp_timer #(
    parameter int CNT_W = 10
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        count_tick,
    input  wire logic        capture_input_pin,
    output logic             timer_out,
    output logic             timer_out_en
);

    if (CNT_W < 9 || CNT_W > 16) begin : g_bad_width
        $error("CNT_W must lie between 9 and 16.");
    end

    stcp_pkg::stcp_ctrl1_t ctrl1;
    stcp_pkg::stcp_req_t   req;
    logic                  req_valid;
    logic                  counter_on;
    logic                  on_prev;
    logic [2:0]            compare_p_value;
    logic [CNT_W-1:0]      count;
    logic [CNT_W-1:0]      compare_a_value;
    logic [7:0]            wbuf;
    logic [7:0]            rbuf;
    logic                  cmp_a_flag;
    logic                  cmp_p_flag;
    logic                  out_level;
    logic                  cap_prev;

    function automatic logic sel(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    // Bus side.
    wire       accept = hsel & htrans[1] & hready;
    wire [7:0] a_off  = haddr[7:0];
    wire       rd_now = accept & ~hwrite;
    wire       wr_now = req_valid & req.write;
    wire [7:0] wd     = hwdata[7:0];
    wire       wr_c0  = wr_now & sel(req.addr, `STCP_OFS_CTRL0);
    wire       wr_c1  = wr_now & sel(req.addr, `STCP_OFS_CTRL1);
    wire       wr_al  = wr_now & sel(req.addr, `STCP_OFS_CMPAL);
    wire       wr_ah  = wr_now & sel(req.addr, `STCP_OFS_CMPAH);
    wire       wr_fl  = wr_now & sel(req.addr, `STCP_OFS_FLAGS);

    wire [7:0] cnt_hi = {{(16-CNT_W){1'b0}}, count[CNT_W-1:8]};
    wire [7:0] cmp_hi = {{(16-CNT_W){1'b0}}, compare_a_value[CNT_W-1:8]};
    wire [7:0] c0_rd  = {4'h0, counter_on, compare_p_value};
    wire [7:0] fl_rd  = {6'h00, cmp_p_flag, cmp_a_flag};
    wire [7:0] rd_byte =
        sel(a_off, `STCP_OFS_CTRL0) ? c0_rd :
        sel(a_off, `STCP_OFS_CTRL1) ? ctrl1 :
        sel(a_off, `STCP_OFS_CNTL)  ? rbuf :
        sel(a_off, `STCP_OFS_CNTH)  ? cnt_hi :
        sel(a_off, `STCP_OFS_CMPAL) ? rbuf :
        sel(a_off, `STCP_OFS_CMPAH) ? cmp_hi :
        sel(a_off, `STCP_OFS_FLAGS) ? fl_rd : `STCP_BYTE_RST;

    // Reading a high byte freezes its low byte, so a pair read is coherent.
    wire rd_cnth = rd_now & sel(a_off, `STCP_OFS_CNTH);
    wire rd_cmph = rd_now & sel(a_off, `STCP_OFS_CMPAH);
    wire [7:0] next_rbuf = rd_cnth ? count[7:0] :
                           rd_cmph ? compare_a_value[7:0] : rbuf;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_valid <= 1'b0;
            req       <= '0;
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            rbuf      <= `STCP_BYTE_RST;
        end else begin
            req_valid <= accept;
            req       <= '{write: hwrite, addr: a_off};
            hrdata    <= rd_now ? {24'h00_0000, rd_byte} : hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            rbuf      <= next_rbuf;
        end
    end

    // Mode decode.
    wire [1:0] mode   = ctrl1.op_mode_sel;
    wire [1:0] action = ctrl1.out_action_sel;
    wire m_cmp  = (mode == `STCP_MODE_CMP) | (mode == `STCP_MODE_TMR);
    wire m_cap  = mode == `STCP_MODE_CAP;
    wire m_pwm  = mode == `STCP_MODE_PWM;
    wire single = m_pwm & (action == `STCP_ACT_11);
    wire swap   = ctrl1.pwm_role_swap;
    wire init   = ctrl1.out_initial_level;

    // Counter and comparators.
    wire              on_rise = counter_on & ~on_prev;
    wire              step    = counter_on & ~on_rise & count_tick;
    wire [CNT_W:0]    cnt_inc = {1'b0, count} + (CNT_W+1)'(1);
    wire              ovf     = cnt_inc[CNT_W];
    wire [CNT_W-1:0]  p_val   = {compare_p_value, {(CNT_W-3){1'b0}}};
    wire              p_zero  = compare_p_value == `STCP_CMPP_RST;
    wire              a_zero  = compare_a_value == '0;
    wire              p_raw   = p_zero ? ovf : cnt_inc == {1'b0, p_val};
    wire              a_raw   = ~a_zero & (cnt_inc == {1'b0, compare_a_value});
    wire              a_per   = a_zero ? ovf : a_raw;
    wire [CNT_W:0]    p_len   = p_zero ? (CNT_W+1)'(1) << CNT_W
                                       : {1'b0, p_val};
    wire [CNT_W:0]    a_len   = a_zero ? (CNT_W+1)'(1) << CNT_W
                                       : {1'b0, compare_a_value};
    wire [CNT_W:0]    period  = swap ? a_len : p_len;
    wire [CNT_W:0]    duty    = swap ? p_len : {1'b0, compare_a_value};

    wire a_hit = step & ((m_pwm & ~single) ? a_per : a_raw);
    wire p_hit = step & p_raw & ~single;

    // Capture edges.
    wire cap_rise = capture_input_pin & ~cap_prev;
    wire cap_fall = ~capture_input_pin & cap_prev;
    wire cap_edge = (action == `STCP_ACT_00) ? cap_rise :
                    (action == `STCP_ACT_01) ? cap_fall :
                    (action == `STCP_ACT_10) ? (cap_rise | cap_fall)
                                             : 1'b0;
    wire cap_ev   = m_cap & counter_on & cap_edge;

    wire a_ev = m_cap ? cap_ev : (~m_pwm | ~single) & a_hit;
    wire p_ev = p_hit & ~(m_cmp & ctrl1.clear_source_sel);

    // Clear source only matters in compare and timer modes.
    wire clr = m_cmp ? (ctrl1.clear_source_sel ? a_hit : p_hit) :
               m_pwm ? (single ? 1'b0 : (swap ? a_hit : p_hit)) :
               p_hit;

    wire [CNT_W-1:0] next_count =
        on_rise ? '0 :
        (step & clr) ? '0 :
        step ? cnt_inc[CNT_W-1:0] : count;

    wire next_a_flag = (cmp_a_flag & ~(wr_fl & wd[`STCP_FLAG_A_BIT])) | a_ev;
    wire next_p_flag = (cmp_p_flag & ~(wr_fl & wd[`STCP_FLAG_P_BIT])) | p_ev;

    wire [CNT_W-1:0] next_cmpa =
        cap_ev ? count :
        wr_ah ? {wd[CNT_W-9:0], wbuf} : compare_a_value;

    // A single pulse ends when compare-A matches; a bus write still wins.
    wire next_on = wr_c0 ? wd[`STCP_ON_BIT] :
                   (single & a_hit) ? 1'b0 : counter_on;

    // Compare output level; a set to the present level is no change.
    wire cmp_out = (action == `STCP_ACT_01) ? 1'b0 :
                   (action == `STCP_ACT_10) ? 1'b1 :
                   (action == `STCP_ACT_11) ? ~out_level : out_level;
    wire next_out_level =
        on_rise ? init :
        ((mode == `STCP_MODE_CMP) & a_ev) ? cmp_out :
        out_level;

    wire pwm_act = (duty >= period) | ({1'b0, count} < duty);
    wire pwm_lvl = (action == `STCP_ACT_00) ? ~init :
                   (action == `STCP_ACT_01) ? init :
                   (action == `STCP_ACT_10) ? (pwm_act ? init : ~init) :
                   (counter_on ? init : ~init);
    wire drive   = (mode == `STCP_MODE_CMP) | m_pwm;
    wire pin_lvl = m_pwm ? pwm_lvl : out_level;
    wire next_timer_out = drive & (pin_lvl ^ ctrl1.out_invert);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl1           <= `STCP_BYTE_RST;
            counter_on      <= 1'b0;
            on_prev         <= 1'b0;
            compare_p_value <= `STCP_CMPP_RST;
            count           <= '0;
            compare_a_value <= '0;
            wbuf            <= `STCP_BYTE_RST;
            cmp_a_flag      <= 1'b0;
            cmp_p_flag      <= 1'b0;
            out_level       <= 1'b0;
            cap_prev        <= 1'b0;
            timer_out       <= 1'b0;
            timer_out_en    <= 1'b0;
        end else begin
            ctrl1           <= wr_c1 ? wd : ctrl1;
            counter_on      <= next_on;
            on_prev         <= counter_on;
            compare_p_value <= wr_c0 ? wd[`STCP_CMPP_MSB:0] : compare_p_value;
            count           <= next_count;
            compare_a_value <= next_cmpa;
            wbuf            <= wr_al ? wd : wbuf;
            cmp_a_flag      <= next_a_flag;
            cmp_p_flag      <= next_p_flag;
            out_level       <= next_out_level;
            cap_prev        <= capture_input_pin;
            timer_out       <= next_timer_out;
            timer_out_en    <= drive;
        end
    end

    // Checks.
    property p_no_p_flag;
        @(posedge hclk) disable iff (!hresetn)
        (mode == `STCP_MODE_CMP && ctrl1.clear_source_sel && !cmp_p_flag)
            |=> !cmp_p_flag;
    endproperty
    a_no_p_flag: assert property (p_no_p_flag)
        else $error("P flag raised with clear source A.");

    property p_on_clears;
        @(posedge hclk) disable iff (!hresetn)
        $rose(counter_on) |=> (count == '0) ##1 (count <= CNT_W'(1));
    endproperty
    a_on_clears: assert property (p_on_clears)
        else $error("Counter not cleared after counter_on rose.");

    property p_init_level;
        @(posedge hclk) disable iff (!hresetn)
        (on_rise && mode == `STCP_MODE_CMP)
            |=> out_level == $past(init);
    endproperty
    a_init_level: assert property (p_init_level)
        else $error("Output not returned to its initial level.");

    property p_tmr_undriven;
        @(posedge hclk) disable iff (!hresetn)
        (mode == `STCP_MODE_TMR) |=> !timer_out && !timer_out_en;
    endproperty
    a_tmr_undriven: assert property (p_tmr_undriven)
        else $error("Pin driven in timer mode.");

    property p_zero_a;
        @(posedge hclk) disable iff (!hresetn)
        (m_cmp && a_zero && !cmp_a_flag) |=> !cmp_a_flag;
    endproperty
    a_zero_a: assert property (p_zero_a)
        else $error("A flag raised with compare-A zero.");

    property p_clear_a;
        @(posedge hclk) disable iff (!hresetn)
        (step && m_cmp && ctrl1.clear_source_sel && a_raw)
            |=> count == '0 && cmp_a_flag;
    endproperty
    a_clear_a: assert property (p_clear_a)
        else $error("Compare-A match did not clear the counter.");

    property p_pwm_period;
        @(posedge hclk) disable iff (!hresetn)
        (step && m_pwm && !single && !swap && p_raw)
            |=> count == '0 && cmp_p_flag;
    endproperty
    a_pwm_period: assert property (p_pwm_period)
        else $error("PWM period end missed.");

    property p_full_duty;
        @(posedge hclk) disable iff (!hresetn)
        (m_pwm && action == `STCP_ACT_10 && duty >= period)
            |=> timer_out == $past(init ^ ctrl1.out_invert);
    endproperty
    a_full_duty: assert property (p_full_duty)
        else $error("Full duty output not active.");

    property p_toggle;
        @(posedge hclk) disable iff (!hresetn)
        (mode == `STCP_MODE_CMP && a_hit && action == `STCP_ACT_11)
            |=> out_level != $past(out_level);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("Toggle action did not toggle.");

    property p_hi_read;
        @(posedge hclk) disable iff (!hresetn)
        rd_cnth |=> hrdata[31:2] == '0;
    endproperty
    a_hi_read: assert property (p_hi_read)
        else $error("Counter high byte upper bits not zero.");

    property p_cmp_p_clear;
        @(posedge hclk) disable iff (!hresetn)
        (step && m_cmp && !ctrl1.clear_source_sel && p_raw)
            |=> count == '0 && cmp_p_flag;
    endproperty
    a_cmp_p_clear: assert property (p_cmp_p_clear)
        else $error("Compare-P match did not clear the counter.");

    property p_pwm_forced;
        @(posedge hclk) disable iff (!hresetn)
        (m_pwm && action == `STCP_ACT_00)
            |=> timer_out == $past(~init ^ ctrl1.out_invert);
    endproperty
    a_pwm_forced: assert property (p_pwm_forced)
        else $error("Forced inactive PWM output not inactive.");

    property p_cmp_hold;
        @(posedge hclk) disable iff (!hresetn)
        (mode == `STCP_MODE_CMP && !a_ev && !on_rise) |=> $stable(out_level);
    endproperty
    a_cmp_hold: assert property (p_cmp_hold)
        else $error("Compare output changed without a compare-A flag.");

    property p_capture;
        @(posedge hclk) disable iff (!hresetn)
        cap_ev |=> cmp_a_flag && compare_a_value == $past(count);
    endproperty
    a_capture: assert property (p_capture)
        else $error("Capture did not load the counter into compare-A.");

endmodule

// >>> test_standard_timer_compare_pwm.sv
// Purpose: Self-checking bench for the standard timer over AHB-Lite.
// Assumes: count_tick is held high once counting starts, one count a clock.
// Notes:   Duty is measured over whole periods, so phase does not matter.
`timescale 1ns/1ps
`include "stcp_defs.svh"

module test_standard_timer_compare_pwm;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = '0;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        count_tick = 1'b0;
    logic        capture_input_pin = 1'b0;
    logic        timer_out;
    logic        timer_out_en;
    int          miscompares = 0;
    int          num_checks = 0;
    int          ones;
    logic [31:0] rd;
    logic [31:0] c1;
    logic [31:0] c2;
    logic [1:0]  act;
    logic        ini;
    logic        pol;
    logic        lvl;
    logic [7:0]  regs [8] = '{`STCP_OFS_CTRL0, `STCP_OFS_CTRL1,
        `STCP_OFS_CNTH, `STCP_OFS_CNTL, `STCP_OFS_CMPAH, `STCP_OFS_CMPAL,
        `STCP_OFS_FLAGS, 8'h1C};
    // PWM cases: action, swap, P code, compare-A, level, invert, window, ones.
    int pact [8] = '{2, 2, 2, 2, 2, 0, 1, 2};
    int psw  [8] = '{0, 0, 0, 1, 0, 0, 0, 0};
    int pcd  [8] = '{1, 1, 2, 1, 0, 1, 1, 7};
    int pa   [8] = '{32, 32, 300, 300, 256, 32, 32, 100};
    int pini [8] = '{1, 1, 1, 0, 1, 1, 1, 1};
    int ppol [8] = '{0, 1, 0, 0, 0, 0, 0, 0};
    int pw   [8] = '{256, 256, 512, 600, 1024, 256, 256, 896};
    int pe   [8] = '{64, 192, 512, 344, 256, 0, 256, 100};

    assign hready = hreadyout;

    stcp_timer u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .count_tick(count_tick),
        .capture_input_pin(capture_input_pin), .timer_out(timer_out),
        .timer_out_en(timer_out_en));

    always #4 hclk = ~hclk;

    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // A hung slave must not hang the run, so every wait has a bound.
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 50) begin
            n++;
            @(posedge hclk);
        end
        if (hready !== 1'b1) begin
            miscompares++;
            report_and_stop();
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input string nm);
        bus(1'b0, a, 32'h0000_0000, rd);
        check(nm, rd, e);
    endtask

    // The high byte is read first so that the low byte comes from one sample.
    task automatic rd_cnt(output logic [31:0] c);
        logic [31:0] h;
        bus(1'b0, `STCP_OFS_CNTH, 32'h0000_0000, h);
        bus(1'b0, `STCP_OFS_CNTL, 32'h0000_0000, rd);
        check("cnt_hi_unused", h >> 2, 32'h0000_0000);
        check("hresp", hresp, 32'h0000_0000);
        c = {22'h00_0000, h[1:0], rd[7:0]};
    endtask

    task automatic wait_flag(input logic [31:0] m);
        int n;
        n = 0;
        rd = '0;
        while ((rd & m) !== m && n < 800) begin
            bus(1'b0, `STCP_OFS_FLAGS, 32'h0000_0000, rd);
            n++;
        end
        if ((rd & m) !== m) begin
            miscompares++;
            report_and_stop();
        end
    endtask

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (regs[i]) begin
            rdc(regs[i], 32'h0000_0000, "reset_value");
        end
        wr(`STCP_OFS_CMPAL, 32'h0000_00A5);
        wr(`STCP_OFS_CMPAH, 32'h0000_00FF);
        rdc(`STCP_OFS_CMPAH, 32'h0000_0003, "cmpa_hi");
        rdc(`STCP_OFS_CMPAL, 32'h0000_00A5, "cmpa_lo");
        count_tick <= 1'b1;
        wr(`STCP_OFS_CMPAL, 32'h0000_00C8);
        wr(`STCP_OFS_CMPAH, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            act = i[1:0];
            ini = i[2];
            pol = i[0] ^ i[2];
            wr(`STCP_OFS_CTRL0, 32'h0000_0000);
            wr(`STCP_OFS_CTRL1, {24'h00_0000, 2'b00, act, ini, pol, 2'b01});
            wr(`STCP_OFS_FLAGS, 32'h0000_0003);
            wr(`STCP_OFS_CTRL0, 32'h0000_0009);
            cycles(3);
            check("out_initial", timer_out, ini ^ pol);
            check("out_enable", timer_out_en, 1'b1);
            wait_flag(32'h0000_0001);
            cycles(3);
            lvl = act == 2'h0 ? ini : act == 2'h1 ? 1'b0 :
                  act == 2'h2 ? 1'b1 : !ini;
            check("out_match", timer_out, lvl ^ pol);
            rdc(`STCP_OFS_FLAGS, 32'h0000_0001, "no_p_flag");
        end
        wr(`STCP_OFS_CMPAL, 32'h0000_0032);
        wr(`STCP_OFS_CMPAH, 32'h0000_0000);
        for (int k = 0; k < 2; k++) begin
            wr(`STCP_OFS_CTRL0, 32'h0000_0000);
            wr(`STCP_OFS_CTRL1, k ? 32'h0000_00C0 : 32'h0000_0000);
            wr(`STCP_OFS_FLAGS, 32'h0000_0003);
            wr(`STCP_OFS_CTRL0, 32'h0000_0009);
            wait_flag(32'h0000_0003);
            check("mode_enable", timer_out_en, !k);
            rd_cnt(c1);
            check("below_p", c1 < 128, 1'b1);
        end
        // Compare-A at zero: only an overflow can clear the counter.
        wr(`STCP_OFS_CTRL0, 32'h0000_0000);
        wr(`STCP_OFS_CMPAL, 32'h0000_0000);
        wr(`STCP_OFS_CMPAH, 32'h0000_0000);
        wr(`STCP_OFS_CTRL1, 32'h0000_0000);
        wr(`STCP_OFS_FLAGS, 32'h0000_0003);
        wr(`STCP_OFS_CTRL0, 32'h0000_0008);
        cycles(1100);
        bus(1'b0, `STCP_OFS_FLAGS, 32'h0000_0000, rd);
        check("no_a_flag", rd[0], 1'b0);
        wr(`STCP_OFS_CTRL0, 32'h0000_0000);
        rd_cnt(c1);
        cycles(5);
        rd_cnt(c2);
        check("count_held", c2, c1);
        wr(`STCP_OFS_CTRL0, 32'h0000_0008);
        // The clear lands one edge after the write that sets counter_on.
        cycles(1);
        rd_cnt(c2);
        check("count_cleared", c2 < 16, 1'b1);
        for (int i = 0; i < 8; i++) begin
            wr(`STCP_OFS_CTRL0, 32'h0000_0000);
            wr(`STCP_OFS_CMPAL, pa[i] & 255);
            wr(`STCP_OFS_CMPAH, pa[i] >> 8);
            wr(`STCP_OFS_CTRL1, {24'h00_0000, 2'b10, pact[i][1:0],
                pini[i][0], ppol[i][0], psw[i][0], 1'b1});
            wr(`STCP_OFS_FLAGS, 32'h0000_0003);
            wr(`STCP_OFS_CTRL0, 8 | pcd[i]);
            cycles(20);
            ones = 0;
            repeat (pw[i]) begin
                @(posedge hclk);
                ones += timer_out;
            end
            check("pwm", ones, pe[i]);
            if (i == 0) begin
                rdc(`STCP_OFS_FLAGS, 32'h0000_0003, "pwm_flags");
            end
        end
        wr(`STCP_OFS_CTRL0, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            wr(`STCP_OFS_CTRL1, {24'h00_0000, 2'b01, i[1:0], 4'h0});
            wr(`STCP_OFS_CTRL0, 32'h0000_0008);
            for (int e = 0; e < 2; e++) begin
                wr(`STCP_OFS_FLAGS, 32'h0000_0003);
                capture_input_pin <= (e == 0);
                cycles(4);
                bus(1'b0, `STCP_OFS_FLAGS, 32'h0000_0000, rd);
                lvl = e ? (i == 1 || i == 2) : (i == 0 || i == 2);
                check("capture_flag", rd[0], lvl);
            end
            wr(`STCP_OFS_CTRL0, 32'h0000_0000);
        end
        report_and_stop();
    end
endmodule
